// ==== common/eep_pkg.sv ====
// Shared constants and types of the two-wire memory slave and its bus master.
package eep_pkg;
	localparam int         CLK_MHZ      = 200;
	localparam int         F_SCL_KHZ    = 100;
	localparam int         SCL_QTR      = (CLK_MHZ * 1000) / (F_SCL_KHZ * 4);
	localparam int         T_WR_US      = 5000;
	localparam int         WR_CYCLES    = T_WR_US * CLK_MHZ;
	localparam int         ADDR_W       = 16;
	localparam int         PAGE_W       = 7;
	localparam logic [3:0] CTRL_CODE    = 4'ha;
	localparam logic [3:0] BIT_FIRST    = 4'h1;
	localparam logic [3:0] LAST_BIT     = 4'h7;
	localparam logic [3:0] ACK_SLOT     = 4'h8;
	localparam logic       DIR_READ     = 1'h1;
	localparam logic [1:0] Q_SET        = 2'h0;
	localparam logic [1:0] Q_RISE       = 2'h1;
	localparam logic [1:0] Q_SAMPLE     = 2'h2;
	localparam logic [1:0] Q_FALL       = 2'h3;
	localparam logic [1:0] BYTE_SLAVE   = 2'h0;
	localparam logic [1:0] BYTE_OFS_HI  = 2'h1;
	localparam logic [1:0] BYTE_OFS_LO  = 2'h2;
	localparam logic [1:0] BYTE_DATA    = 2'h3;

	typedef enum logic [2:0] {
		DP_IGNORE,
		DP_ADDR,
		DP_OFS_HI,
		DP_OFS_LO,
		DP_WDATA,
		DP_RDATA
	} eep_dphase_t;

	typedef enum logic [1:0] {
		H_IDLE,
		H_START,
		H_BIT,
		H_STOP
	} eep_hstate_t;
endpackage

// ==== common/eep_if.sv ====
// Two-wire bus between master and memory slave, with open-drain resolution.
`timescale 1ns/1ps
interface eep_if;
	logic scl;
	logic sda;
	logic host_sda_o;
	logic host_sda_oe_n;
	logic dev_sda_o;
	logic dev_sda_oe_n;

	// Pull-up: line is low only where an enabled driver pulls it low
	assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

	modport host (
		output scl,
		output host_sda_o,
		output host_sda_oe_n,
		input  sda
	);

	modport dev (
		input  scl,
		input  sda,
		output dev_sda_o,
		output dev_sda_oe_n
	);
endinterface

// ==== rtl/eep_host.sv ====
// Bus master: byte write and current-address read over the two-wire bus.
`timescale 1ns/1ps
module eep_host #(
	parameter int SCL_QTR = eep_pkg::SCL_QTR
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// Command
	input  wire logic        cmd_valid,
	output logic             cmd_ready,
	input  wire logic        cmd_read,
	input  wire logic [2:0]  cmd_sel,
	input  wire logic [15:0] cmd_addr,
	input  wire logic [7:0]  cmd_data,
	// Response
	output logic             rsp_valid,
	output logic             rsp_nak,
	output logic [7:0]       rsp_data,
	// Bus
	eep_if.host              bus
);
	localparam int DIV_W = $clog2(SCL_QTR + 1);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCL_QTR - 1);

	typedef struct packed {
		eep_pkg::eep_hstate_t st;
		logic [DIV_W-1:0]     div;
		logic [1:0]           q;
		logic [3:0]           bitn;
		logic [1:0]           byten;
		logic [7:0]           shift;
		logic                 rd;
		logic [2:0]           sel;
		logic [15:0]          addr;
		logic [7:0]           data;
		logic [7:0]           rx;
		logic                 nak;
		logic                 scl;
		logic                 sda_low;
		logic                 rsp_valid;
		logic                 sda_s1;
		logic                 sda_s2;
	} eep_host_t;

	eep_host_t r_r;
	eep_host_t r_nxt;

	function automatic logic [7:0] frame_byte(input eep_host_t s, input logic [1:0] idx);
		unique case (idx)
			eep_pkg::BYTE_SLAVE:  frame_byte = {eep_pkg::CTRL_CODE, s.sel, s.rd};
			eep_pkg::BYTE_OFS_HI: frame_byte = s.addr[15:8];
			eep_pkg::BYTE_OFS_LO: frame_byte = s.addr[7:0];
			eep_pkg::BYTE_DATA:   frame_byte = s.data;
		endcase
	endfunction

	logic tx_byte;
	logic last_byte;

	always_comb begin
		r_nxt = r_r;
		r_nxt.sda_s1 = bus.sda;
		r_nxt.sda_s2 = r_r.sda_s1;
		r_nxt.rsp_valid = 1'b0;
		tx_byte = !(r_r.rd && r_r.byten == eep_pkg::BYTE_OFS_HI);
		last_byte = r_r.rd ? (r_r.byten == eep_pkg::BYTE_OFS_HI) :
			(r_r.byten == eep_pkg::BYTE_DATA);
		if (r_r.st != eep_pkg::H_IDLE) begin
			r_nxt.div = (r_r.div == DIV_LAST) ? '0 : r_r.div + 1'b1;
		end
		if (sys_rst) begin
			r_nxt.st = eep_pkg::H_IDLE;
			r_nxt.div = '0;
			r_nxt.q = eep_pkg::Q_SET;
			r_nxt.scl = 1'b1;
			r_nxt.sda_low = 1'b0;
			r_nxt.nak = 1'b0;
			r_nxt.rx = 8'h00;
		end else if (r_r.st == eep_pkg::H_IDLE) begin
			// Commands start only from idle, bus released high
			if (cmd_valid) begin
				r_nxt.st = eep_pkg::H_START;
				r_nxt.rd = cmd_read;
				r_nxt.sel = cmd_sel;
				r_nxt.addr = cmd_addr;
				r_nxt.data = cmd_data;
				r_nxt.nak = 1'b0;
				r_nxt.q = eep_pkg::Q_SET;
			end
		end else if (r_r.div == DIV_LAST) begin
			r_nxt.q = r_r.q + 1'b1;
			unique case (r_r.st)
				eep_pkg::H_START: begin
					if (r_r.q == eep_pkg::Q_SAMPLE) begin
						r_nxt.sda_low = 1'b1;
					end else if (r_r.q == eep_pkg::Q_FALL) begin
						r_nxt.scl = 1'b0;
						r_nxt.st = eep_pkg::H_BIT;
						r_nxt.bitn = 4'h0;
						r_nxt.byten = eep_pkg::BYTE_SLAVE;
						r_nxt.shift = frame_byte(r_r, eep_pkg::BYTE_SLAVE);
					end
				end
				eep_pkg::H_BIT: begin
					unique case (r_r.q)
						eep_pkg::Q_SET: begin
							// Read byte and every ack slot are released
							r_nxt.sda_low = tx_byte && r_r.bitn != eep_pkg::ACK_SLOT &&
								!r_r.shift[7];
						end
						eep_pkg::Q_RISE: r_nxt.scl = 1'b1;
						eep_pkg::Q_SAMPLE: begin
							if (r_r.bitn != eep_pkg::ACK_SLOT) begin
								r_nxt.rx = {r_r.rx[6:0], r_r.sda_s2};
							end else if (tx_byte && r_r.sda_s2) begin
								r_nxt.nak = 1'b1;
							end
						end
						eep_pkg::Q_FALL: begin
							r_nxt.scl = 1'b0;
							if (r_r.bitn != eep_pkg::ACK_SLOT) begin
								r_nxt.shift = {r_r.shift[6:0], 1'b0};
								r_nxt.bitn = r_r.bitn + 4'h1;
							end else if (r_nxt.nak || last_byte) begin
								r_nxt.st = eep_pkg::H_STOP;
							end else begin
								r_nxt.bitn = 4'h0;
								r_nxt.byten = r_r.byten + 1'b1;
								r_nxt.shift = frame_byte(r_r, r_r.byten + 1'b1);
							end
						end
					endcase
				end
				eep_pkg::H_STOP: begin
					unique case (r_r.q)
						eep_pkg::Q_SET:    r_nxt.sda_low = 1'b1;
						eep_pkg::Q_RISE:   r_nxt.scl = 1'b1;
						eep_pkg::Q_SAMPLE: r_nxt.sda_low = 1'b0;
						eep_pkg::Q_FALL: begin
							r_nxt.st = eep_pkg::H_IDLE;
							r_nxt.rsp_valid = 1'b1;
						end
					endcase
				end
				default: r_nxt.st = eep_pkg::H_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		r_r <= r_nxt;
	end

	assign cmd_ready = (r_r.st == eep_pkg::H_IDLE) && !sys_rst;
	assign rsp_valid = r_r.rsp_valid;
	assign rsp_nak = r_r.nak;
	assign rsp_data = r_r.rx;
	assign bus.scl = r_r.scl;
	assign bus.host_sda_o = 1'b0;
	assign bus.host_sda_oe_n = !r_r.sda_low;
endmodule

// ==== rtl/eep_dev.sv ====
// Two-wire memory slave: bit engine on SCL, write cycle and memory on clk.
`timescale 1ns/1ps
module eep_dev #(
	parameter int ADDR_W    = eep_pkg::ADDR_W,
	parameter int PAGE_W    = eep_pkg::PAGE_W,
	parameter int WR_CYCLES = eep_pkg::WR_CYCLES
) (
	// System clock and power-on reset
	input  wire logic              clk,
	input  wire logic              sys_rst,
	// Straps
	input  wire logic              wp,
	input  wire logic              device_select_bit0,
	input  wire logic              device_select_bit1,
	input  wire logic              device_select_bit2,
	// Status
	output logic                   write_busy,
	output logic                   write_done,
	// Backdoor look into the array
	input  wire logic [ADDR_W-1:0] peek_addr,
	output logic [7:0]             peek_data,
	// Bus
	eep_if.dev                     bus
);
	localparam int WR_W = $clog2(WR_CYCLES + 1);
	localparam logic [WR_W-1:0] WR_LAST = WR_W'(WR_CYCLES - 1);

	typedef struct packed {
		logic                 rst_s1;
		logic                 rst_s2;
		logic                 start_seen;
		logic                 busy_s1;
		logic                 busy_s2;
		logic [2:0]           sel_s1;
		logic [2:0]           sel_s2;
		eep_pkg::eep_dphase_t phase;
		logic [3:0]           cnt;
		logic [7:0]           shift;
		logic                 ack;
		logic [ADDR_W-1:0]    addr;
		logic [ADDR_W-1:0]    wr_addr;
		logic [7:0]           wr_data;
		logic                 wr_pend;
		logic [7:0]           tx;
	} eep_link_t;

	typedef struct packed {
		logic            stop_s1;
		logic            stop_s2;
		logic            stop_seen;
		logic            wp_s1;
		logic            wp_s2;
		logic            pend_s1;
		logic            pend_s2;
		logic            busy;
		logic            done;
		logic [WR_W-1:0] cnt;
		logic [7:0]      peek;
	} eep_core_t;

	logic [7:0] mem [2**ADDR_W];

	eep_link_t l_r;
	eep_link_t l_nxt;
	eep_core_t c_r;
	eep_core_t c_nxt;
	logic      start_tgl_r;
	logic      stop_tgl_r;
	logic      start_lnk_r;
	logic      drive_low_r;
	logic      drive_low_nxt;
	logic [7:0] byte_in;
	logic      addr_match;
	logic      commit;

	// Byte counter wraps inside its page on writes; reads step across the whole array
	function automatic logic [ADDR_W-1:0] page_inc(input logic [ADDR_W-1:0] a);
		page_inc = {a[ADDR_W-1:PAGE_W], a[PAGE_W-1:0] + 1'b1};
	endfunction

	// START and STOP are SDA edges while SCL is high; only these flops see SDA as a clock
	always_ff @(negedge bus.sda or posedge sys_rst) begin
		if (sys_rst) begin
			start_tgl_r <= 1'b0;
		end else if (bus.scl) begin
			start_tgl_r <= ~start_tgl_r;
		end
	end

	always_ff @(posedge bus.sda or posedge sys_rst) begin
		if (sys_rst) begin
			stop_tgl_r <= 1'b0;
		end else if (bus.scl) begin
			stop_tgl_r <= ~stop_tgl_r;
		end
	end

	// Link side: bits taken on SCL rise
	always_comb begin
		byte_in = {l_r.shift[6:0], bus.sda};
		addr_match = byte_in[7:4] == eep_pkg::CTRL_CODE &&
			byte_in[3:1] == l_r.sel_s2 &&
			!l_r.busy_s2;
		l_nxt = l_r;
		l_nxt.rst_s1 = sys_rst;
		l_nxt.rst_s2 = l_r.rst_s1;
		l_nxt.start_seen = start_lnk_r;
		l_nxt.busy_s1 = c_r.busy;
		l_nxt.busy_s2 = l_r.busy_s1;
		l_nxt.sel_s1 = {device_select_bit2, device_select_bit1, device_select_bit0};
		l_nxt.sel_s2 = l_r.sel_s1;
		if (l_r.rst_s2) begin
			// SCL may stand still, so this only takes hold at the next SCL edges
			l_nxt.phase = eep_pkg::DP_IGNORE;
			l_nxt.cnt = 4'h0;
			l_nxt.ack = 1'b0;
			l_nxt.wr_pend = 1'b0;
			l_nxt.addr = '0;
		end else if (start_lnk_r != l_r.start_seen) begin
			// First address bit is sampled on this same edge
			l_nxt.phase = eep_pkg::DP_ADDR;
			l_nxt.cnt = eep_pkg::BIT_FIRST;
			l_nxt.shift = {7'h00, bus.sda};
			l_nxt.ack = 1'b0;
			l_nxt.wr_pend = 1'b0;
		end else if (l_r.cnt == eep_pkg::ACK_SLOT) begin
			l_nxt.cnt = 4'h0;
			l_nxt.ack = 1'b0;
			if (l_r.phase == eep_pkg::DP_RDATA) begin
				// Ack high here means the address ack just ended
				if (l_r.ack || !bus.sda) begin
					l_nxt.tx = mem[l_r.addr];
					l_nxt.addr = l_r.addr + 1'b1;
				end else begin
					l_nxt.phase = eep_pkg::DP_IGNORE;
				end
			end
		end else if (l_r.phase != eep_pkg::DP_IGNORE) begin
			l_nxt.shift = byte_in;
			l_nxt.cnt = l_r.cnt + 4'h1;
			if (l_r.cnt == eep_pkg::LAST_BIT) begin
				unique case (l_r.phase)
					eep_pkg::DP_ADDR: begin
						if (addr_match) begin
							l_nxt.ack = 1'b1;
							l_nxt.phase = (byte_in[0] == eep_pkg::DIR_READ) ?
								eep_pkg::DP_RDATA : eep_pkg::DP_OFS_HI;
						end else begin
							l_nxt.phase = eep_pkg::DP_IGNORE;
							l_nxt.cnt = 4'h0;
						end
					end
					eep_pkg::DP_OFS_HI: begin
						l_nxt.ack = 1'b1;
						l_nxt.addr = ADDR_W'({byte_in, l_r.addr[7:0]});
						l_nxt.phase = eep_pkg::DP_OFS_LO;
					end
					eep_pkg::DP_OFS_LO: begin
						l_nxt.ack = 1'b1;
						l_nxt.addr = {l_r.addr[ADDR_W-1:8], byte_in};
						l_nxt.phase = eep_pkg::DP_WDATA;
					end
					eep_pkg::DP_WDATA: begin
						// Further bytes replace the pending one at the next location
						l_nxt.ack = 1'b1;
						l_nxt.wr_data = byte_in;
						l_nxt.wr_addr = l_r.addr;
						l_nxt.wr_pend = 1'b1;
						l_nxt.addr = page_inc(l_r.addr);
					end
					eep_pkg::DP_RDATA: l_nxt.ack = 1'b0;
					default: l_nxt.phase = eep_pkg::DP_IGNORE;
				endcase
			end
		end
	end

	// Link side: pin changes on SCL fall, pull low or release only
	always_comb begin
		drive_low_nxt = 1'b0;
		if (l_r.rst_s2) begin
			drive_low_nxt = 1'b0;
		end else if (l_r.cnt == eep_pkg::ACK_SLOT) begin
			drive_low_nxt = l_r.ack;
		end else if (l_r.phase == eep_pkg::DP_RDATA) begin
			drive_low_nxt = !l_r.tx[~l_r.cnt[2:0]];
		end
	end

	// SCL stands still in reset, so the link clears at once or the first START is lost
	always_ff @(posedge bus.scl or posedge sys_rst) begin
		if (sys_rst) begin
			l_r <= '0;
		end else begin
			l_r <= l_nxt;
		end
	end

	// Toggle settled a quarter SCL period before this sample
	always_ff @(negedge bus.scl or posedge sys_rst) begin
		if (sys_rst) begin
			start_lnk_r <= 1'b0;
			drive_low_r <= 1'b0;
		end else begin
			start_lnk_r <= start_tgl_r;
			drive_low_r <= drive_low_nxt;
		end
	end

	// Core side: STOP taken over from the link, which may stop clocking
	always_comb begin
		c_nxt = c_r;
		c_nxt.stop_s1 = stop_tgl_r;
		c_nxt.stop_s2 = c_r.stop_s1;
		c_nxt.stop_seen = c_r.stop_s2;
		c_nxt.wp_s1 = wp;
		c_nxt.wp_s2 = c_r.wp_s1;
		c_nxt.pend_s1 = l_r.wr_pend;
		c_nxt.pend_s2 = c_r.pend_s1;
		c_nxt.done = 1'b0;
		c_nxt.peek = mem[peek_addr];
		commit = 1'b0;
		if (sys_rst) begin
			c_nxt = '0;
		end else if (c_r.busy) begin
			if (c_r.cnt == '0) begin
				c_nxt.busy = 1'b0;
				c_nxt.done = 1'b1;
			end else begin
				c_nxt.cnt = c_r.cnt - 1'b1;
			end
		end else if (c_r.stop_s2 != c_r.stop_seen && c_r.pend_s2) begin
			// Protected: sequence was acked but nothing is committed
			if (!c_r.wp_s2) begin
				commit = 1'b1;
				c_nxt.busy = 1'b1;
				c_nxt.cnt = WR_LAST;
			end
		end
	end

	always_ff @(posedge clk) begin
		c_r <= c_nxt;
	end

	// Link holds address and data steady from the last data byte until the next START
	always_ff @(posedge clk) begin
		if (commit) begin
			mem[l_r.wr_addr] <= l_r.wr_data;
		end
	end

	assign write_busy = c_r.busy;
	assign write_done = c_r.done;
	assign peek_data = c_r.peek;
	assign bus.dev_sda_o = 1'b0;
	assign bus.dev_sda_oe_n = !drive_low_r;
endmodule

// ==== test/eep_sva.sv ====
// Link checker for the two-wire bus between master and memory slave.
`timescale 1ns/1ps
module eep_sva (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Link
	input wire logic scl,
	input wire logic sda,
	input wire logic host_sda_o,
	input wire logic host_sda_oe_n,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe_n,
	// Device status and straps
	input wire logic write_busy,
	input wire logic device_select_bit0,
	input wire logic device_select_bit1,
	input wire logic device_select_bit2
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	logic       scl_q;
	logic       sda_q;
	logic [3:0] bit_r;
	logic [2:0] byte_r;
	logic [7:0] sh_r;
	logic       rw_r;
	logic       hit_r;
	logic       rise9;

	// Ninth rising clock of a byte: the acknowledge slot
	assign rise9 = scl && !scl_q && bit_r == 4'h8;

	always_ff @(posedge clk) begin
		scl_q <= scl;
		sda_q <= sda;
		if (sys_rst) begin
			bit_r  <= 4'h0;
			byte_r <= 3'h0;
			rw_r   <= 1'h0;
			hit_r  <= 1'h0;
		end else if (scl && scl_q && sda_q && !sda) begin
			bit_r  <= 4'h0;
			byte_r <= 3'h0;
		end else if (scl && !scl_q) begin
			sh_r  <= {sh_r[6:0], sda};
			bit_r <= (bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1;
			if (bit_r == 4'h8 && byte_r != 3'h7)
				byte_r <= byte_r + 3'h1;
			if (bit_r == 4'h7 && byte_r == 3'h0) begin
				rw_r  <= sda;
				hit_r <= sh_r[6:0] == {4'ha, device_select_bit2, device_select_bit1,
					device_select_bit0};
			end
		end
	end

	a_addr_ack_hit: assert property (rise9 && byte_r == 3'h0 && hit_r && !write_busy
		|-> !dev_sda_oe_n) else $error("address not acknowledged");
	a_addr_nak_miss: assert property (rise9 && byte_r == 3'h0 && !hit_r
		|-> dev_sda_oe_n) else $error("foreign address acknowledged");
	a_busy_no_ack: assert property (rise9 && write_busy |-> dev_sda_oe_n)
		else $error("acknowledge during write cycle");
	a_write_bytes_ack: assert property (rise9 && byte_r inside {[1:3]} && !rw_r && hit_r
		|-> !dev_sda_oe_n) else $error("write byte not acknowledged");
	a_read_release: assert property (rise9 && byte_r == 3'h1 && rw_r |-> dev_sda_oe_n)
		else $error("slave holds sda in read acknowledge slot");
	a_dev_change_low: assert property ($changed(dev_sda_oe_n) |-> !scl)
		else $error("slave changed sda while scl high");
	a_dev_open_drain: assert property (!dev_sda_oe_n |-> !dev_sda_o)
		else $error("slave drives sda high");
	a_host_open_drain: assert property (!host_sda_oe_n |-> !host_sda_o)
		else $error("master drives sda high");
	a_scl_reset_high: assert property ($fell(sys_rst) |-> scl)
		else $error("scl not idle after reset");
	a_stop_then_idle: assert property ($rose(host_sda_oe_n) && scl && $past(scl)
		|-> scl [*8]) else $error("bus not idle after stop");
endmodule

// ==== test/serial_eeprom_i2c_slave_byte_write_tb_top.sv ====
// Self-checking bench: master and memory slave joined on one two-wire bus.
`timescale 1ns/1ps
module serial_eeprom_i2c_slave_byte_write_tb_top;
	localparam int WR_N = 1500;
	logic        clk;
	logic        sys_rst;
	logic        cmd_valid;
	logic        cmd_ready;
	logic        cmd_read;
	logic [2:0]  cmd_sel;
	logic [15:0] cmd_addr;
	logic [7:0]  cmd_data;
	logic        rsp_valid;
	logic        rsp_nak;
	logic [7:0]  rsp_data;
	logic        wp;
	logic [2:0]  dsel;
	logic        write_busy;
	logic        write_done;
	logic [15:0] peek_addr;
	logic [7:0]  peek_data;
	logic [15:0] a;
	logic [15:0] b;
	logic [7:0]  d0;
	logic [7:0]  d1;
	integer      seed;
	int          fails;
	int          compares;

	eep_if bus_if ();
	eep_host #(.SCL_QTR(4)) eep_host_i (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_sel(cmd_sel), .cmd_addr(cmd_addr),
		.cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_nak(rsp_nak), .rsp_data(rsp_data),
		.bus(bus_if.host));
	eep_dev #(.WR_CYCLES(WR_N)) eep_dev_i (.clk(clk), .sys_rst(sys_rst), .wp(wp),
		.device_select_bit0(dsel[0]), .device_select_bit1(dsel[1]),
		.device_select_bit2(dsel[2]), .write_busy(write_busy), .write_done(write_done),
		.peek_addr(peek_addr), .peek_data(peek_data), .bus(bus_if.dev));
	eep_sva eep_sva_i (.clk(clk), .sys_rst(sys_rst), .scl(bus_if.scl), .sda(bus_if.sda),
		.host_sda_o(bus_if.host_sda_o), .host_sda_oe_n(bus_if.host_sda_oe_n),
		.dev_sda_o(bus_if.dev_sda_o), .dev_sda_oe_n(bus_if.dev_sda_oe_n),
		.write_busy(write_busy), .device_select_bit0(dsel[0]),
		.device_select_bit1(dsel[1]), .device_select_bit2(dsel[2]));

	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end

	task automatic report_and_stop();
		$display("mismatches %0d comparisons %0d", fails, compares);
		if (fails == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tick();
		@(posedge clk);
		#1;
	endtask

	// Next byte of a page: low seven bits wrap
	function automatic logic [15:0] page_next(input logic [15:0] ad);
		page_next = {ad[15:7], ad[6:0] + 7'h1};
	endfunction

	// A wait that runs out is a mismatch and ends the run
	task automatic hung();
		chk(16'h0, 16'h1);
		report_and_stop();
	endtask

	task automatic do_cmd(input logic rd, input logic [2:0] sel, input logic [15:0] ad,
			input logic [7:0] d);
		int n;
		cmd_read = rd;
		cmd_sel = sel;
		cmd_addr = ad;
		cmd_data = d;
		cmd_valid = 1'h1;
		n = 0;
		while (cmd_ready !== 1'h1 && n < 100) begin
			tick();
			n++;
		end
		if (n >= 100)
			hung();
		tick();
		cmd_valid = 1'h0;
		n = 0;
		while (rsp_valid !== 1'h1 && n < 2000) begin
			tick();
			n++;
		end
		if (n >= 2000)
			hung();
	endtask

	// Busy cycles seen must fall in lo..hi; hi of 0 means no write cycle may start
	task automatic wait_done(input int lo, input int hi);
		int n;
		int busy_n;
		n = 0;
		busy_n = 0;
		while (write_done !== 1'h1 && n < WR_N + 200) begin
			tick();
			n++;
			if (write_busy === 1'h1)
				busy_n++;
		end
		if (hi > 0 && n >= WR_N + 200)
			hung();
		chk({15'h0, busy_n >= lo && busy_n <= hi}, 16'h1);
	endtask

	task automatic peek_chk(input logic [15:0] ad, input logic [7:0] exp);
		peek_addr = ad;
		tick();
		tick();
		chk({8'h0, peek_data}, {8'h0, exp});
	endtask

	initial begin
		seed = 4;
		{cmd_valid, cmd_read, cmd_sel, cmd_addr, cmd_data} = '0;
		{wp, dsel, peek_addr} = '0;
		sys_rst = 1'h1;
		repeat (4) @(posedge clk);
		#1;
		sys_rst = 1'h0;
		tick();
		// First START after reset must be answered; protected, so no cycle starts
		wp = 1'h1;
		do_cmd(1'h0, 3'h0, 16'h0, 8'h0);
		chk({15'h0, rsp_nak}, 16'h0);
		wp = 1'h0;
		for (int s = 0; s < 8; s++) begin
			dsel = 3'(s);
			a = 16'($random(seed));
			// Last byte of a page: the counter must wrap inside the page
			if (s < 3)
				a[6:0] = 7'h7f;
			b = page_next(a);
			d0 = 8'($random(seed));
			d1 = 8'($random(seed));
			do_cmd(1'h1, dsel ^ 3'(1 + {$random(seed)} % 7), 16'h0, 8'h0);
			chk({15'h0, rsp_nak}, 16'h1);
			do_cmd(1'h0, dsel, b, d1);
			chk({15'h0, rsp_nak}, 16'h0);
			do_cmd(1'h1, dsel, 16'h0, 8'h0);
			chk({15'h0, rsp_nak}, 16'h1);
			wait_done(1, WR_N);
			do_cmd(1'h0, dsel, a, d0);
			chk({15'h0, rsp_nak}, 16'h0);
			wait_done(WR_N - 8, WR_N);
			do_cmd(1'h1, dsel, 16'h0, 8'h0);
			chk({15'h0, rsp_nak}, 16'h0);
			chk({8'h0, rsp_data}, {8'h0, d1});
			peek_chk(a, d0);
			wp = 1'h1;
			do_cmd(1'h0, dsel, a, ~d0);
			chk({15'h0, rsp_nak}, 16'h0);
			wait_done(0, 0);
			peek_chk(a, d0);
			wp = 1'h0;
		end
		report_and_stop();
	end
endmodule
